/* File: core/spi_flash_status_id_regs.vh */
// opcode, status field and timing constants for the status/id command block
// assumes inclusion by the command block only
`ifndef SPI_FLASH_STATUS_ID_REGS_VH
`define SPI_FLASH_STATUS_ID_REGS_VH

// fixed opcodes
`define OPC_WRITE_DISABLE 8'h04
`define OPC_STATUS_READ 8'h05
`define OPC_STD_IDENT 8'h9F
`define OPC_LEGACY_IDENT_A 8'h90
`define OPC_LEGACY_IDENT_B 8'hAB
// default opcodes for the parameterised commands
`define OPC_WRITE_ENABLE_DEF 8'h06
`define OPC_STATUS_WRITE_ARM_DEF 8'h50
`define OPC_STATUS_WRITE_DEF 8'h01
`define OPC_STATUS_READ_SECOND_DEF 8'h35
// default primary status bit positions
`define POS_BUSY_DEF 0
`define POS_WRITE_LATCH_DEF 1
`define POS_LEVEL0_DEF 2
`define POS_LEVEL1_DEF 3
`define POS_AUTO_INC_DEF 6
`define POS_LOCK_DEF 7
// default secondary status bit positions
`define POS_TOP_PROT_DEF 2
`define POS_BOT_PROT_DEF 3
// reset values
`define STATUS_PRI_RESET 8'h00
`define STATUS_SEC_RESET 8'h00
// byte program time in ns and clock period in ns
`define BYTE_PROGRAM_TIME_NS 10000
`define CLK_PERIOD_NS 100
// legacy ident address bits after the opcode
`define LEGACY_ADDR_BITS 24

`endif

/* File: core/spi_flash_status_id_commands.v */
// status read, write latch, status write and ident commands of a serial flash
// assumes spi mode 0 host on pins, sampled by a faster system clock
// assumes serial clock half periods of at least four system clocks
// assumes busy and auto increment come from the program/erase engine
//
// Operation
// - status read answered even while busy
// - primary status repeats until select rises
// - secondary status read repeats until select rises
// - write enable sets write latch bit
// - status write clears write latch at end
// - write disable clears latch and auto increment
// - write disable does not abort running program
// - arm must directly precede status write
// - one byte updates lock and level bits
// - locked and pin low ignores status write
// - pin low lets lock only go up
// - pin high makes all protect bits writable
// - judge lock and pin at select rise
// - two bytes load primary then secondary
// - only exactly one or two bytes execute
// - standard ident sends maker, type, capacity
// - select rise stops standard ident output
// - legacy ident needs 24 address bits first
// - legacy ident alternates maker and device code
// - write disable 04, status read 05
// - busy bit shows internal cycle running
`timescale 1ns/1ps
`default_nettype none
`include "spi_flash_status_id_regs.vh"

module spi_flash_status_id_commands #(
  parameter [7:0] WRITE_ENABLE_OPC = `OPC_WRITE_ENABLE_DEF,
  parameter [7:0] STATUS_WRITE_ARM_OPC = `OPC_STATUS_WRITE_ARM_DEF,
  parameter [7:0] STATUS_WRITE_OPC = `OPC_STATUS_WRITE_DEF,
  parameter [7:0] STATUS_READ_SECOND_OPC = `OPC_STATUS_READ_SECOND_DEF,
  parameter integer BUSY_POS = `POS_BUSY_DEF,
  parameter integer WRITE_LATCH_POS = `POS_WRITE_LATCH_DEF,
  parameter integer LEVEL0_POS = `POS_LEVEL0_DEF,
  parameter integer LEVEL1_POS = `POS_LEVEL1_DEF,
  parameter integer AUTO_INC_POS = `POS_AUTO_INC_DEF,
  parameter integer LOCK_POS = `POS_LOCK_DEF,
  parameter integer TOP_PROT_POS = `POS_TOP_PROT_DEF,
  parameter integer BOT_PROT_POS = `POS_BOT_PROT_DEF,
  parameter [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter [7:0] MEM_TYPE_CODE = 8'h3C, // arbitrary value
  parameter [7:0] CAPACITY_CODE = 8'h12 // arbitrary value
) (
  input wire clk_sys_i, // system clock, 10 MHz
  input wire rst_n_i, // synchronous reset, active low
  input wire chip_sel_n_i, // host chip select, active low
  input wire sclk_i, // host serial clock
  input wire sdi_i, // host serial data in
  input wire prog_busy_i, // internal program/erase cycle running
  input wire auto_inc_set_i, // auto increment mode entered
  input wire write_prot_n_i, // write-protect pin, active low
  output reg sdo_o, // serial data out
  output reg sdo_oe_o, // serial data out drive enable
  output reg [7:0] status_pri_o, // primary status register
  output reg [7:0] status_sec_o // secondary status register
);

  // frame states
  localparam [2:0] ST_OPC = 3'h0;
  localparam [2:0] ST_STAT1 = 3'h1;
  localparam [2:0] ST_STAT2 = 3'h2;
  localparam [2:0] ST_STDID = 3'h3;
  localparam [2:0] ST_LADDR = 3'h4;
  localparam [2:0] ST_LID = 3'h5;
  localparam [2:0] ST_WDATA = 3'h6;
  localparam [2:0] ST_SKIP = 3'h7;
  // last legacy ident address bit, counted from zero
  localparam [31:0] ADDR_LAST = `LEGACY_ADDR_BITS - 1;

  // bit-select helper used for both status registers
  function [7:0] put_bit;
    input [7:0] val;
    input integer pos;
    input b;
    begin
      put_bit = val;
      put_bit[pos] = b;
    end
  endfunction

  // states in which the block drives the serial output
  function answer_state;
    input [2:0] st;
    begin
      answer_state = (st == ST_STAT1) || (st == ST_STAT2) ||
        (st == ST_STDID) || (st == ST_LID);
    end
  endfunction

  // two-flop synchronisers for the host pins, write-protect pin and busy input
  reg [1:0] cs_sync_q;
  reg [1:0] sck_sync_q;
  reg [1:0] sdi_sync_q;
  reg [1:0] wp_sync_q;
  reg [1:0] busy_sync_q;
  // third flops keep the previous level for edge finding
  reg cs_n_q;
  reg sck_q;
  // reset levels match the idle pins, so no false edge follows
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cs_sync_q <= 2'h3;
      sck_sync_q <= 2'h0;
      sdi_sync_q <= 2'h0;
      wp_sync_q <= 2'h3;
      busy_sync_q <= 2'h0;
      cs_n_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      cs_sync_q <= {cs_sync_q[0], chip_sel_n_i};
      sck_sync_q <= {sck_sync_q[0], sclk_i};
      sdi_sync_q <= {sdi_sync_q[0], sdi_i};
      wp_sync_q <= {wp_sync_q[0], write_prot_n_i};
      busy_sync_q <= {busy_sync_q[0], prog_busy_i};
      cs_n_q <= cs_sync_q[1];
      sck_q <= sck_sync_q[1];
    end
  end

  // synchronised pin levels and edges, serial clock edges only inside a frame
  wire cs_n = cs_sync_q[1];
  wire sel_fall = cs_n_q && !cs_n;
  wire sel_rise = !cs_n_q && cs_n;
  wire sck_rise = !cs_n && !sck_q && sck_sync_q[1];
  wire sck_fall = !cs_n && sck_q && !sck_sync_q[1];
  wire sdi_s = sdi_sync_q[1];
  wire wp_pin_high = wp_sync_q[1];

  // frame state
  reg [2:0] state_q;
  reg [7:0] opc_q;
  reg [7:0] shin_q;
  reg [4:0] bitcnt_q;
  reg [4:0] wcnt_q;
  reg [1:0] idx_q;
  reg [7:0] shout_q;
  reg [7:0] wbyte0_q;
  reg [7:0] wbyte1_q;
  reg armed_q;

  // byte being shifted in, complete at the eighth rising edge
  wire [7:0] opc_next = {shin_q[6:0], sdi_s};
  wire byte_done = (bitcnt_q == 5'd7);

  // next output byte for repeating answers
  reg [7:0] ans_byte;
  always @* begin
    ans_byte = 8'h00;
    case (state_q)
      ST_STAT1: ans_byte = status_pri_o;
      ST_STAT2: ans_byte = status_sec_o;
      ST_STDID: begin
        if (idx_q == 2'd0) begin
          ans_byte = MAKER_CODE;
        end else if (idx_q == 2'd1) begin
          ans_byte = MEM_TYPE_CODE;
        end else begin
          // capacity code repeats after the third byte
          ans_byte = CAPACITY_CODE;
        end
      end
      ST_LID: ans_byte = idx_q[0] ? CAPACITY_CODE : MAKER_CODE;
      default: ans_byte = 8'h00;
    endcase
  end

  // status write judgement at the rising select edge
  wire wsr_locked = !wp_pin_high && status_pri_o[LOCK_POS];
  // exactly one or two whole bytes after the opcode
  wire wsr_len_ok = (wcnt_q == 5'd8) || (wcnt_q == 5'd16);
  wire wsr_frame = (opc_q == STATUS_WRITE_OPC) && (state_q == ST_WDATA);
  // armed by the frame just before, or write latch set
  wire wsr_allowed = armed_q || status_pri_o[WRITE_LATCH_POS];
  wire wsr_go = wsr_frame && wsr_allowed && wsr_len_ok && !wsr_locked;

  // new primary value from the first data byte
  reg [7:0] pri_new;
  always @* begin
    pri_new = status_pri_o;
    pri_new = put_bit(pri_new, LEVEL0_POS, wbyte0_q[LEVEL0_POS]);
    pri_new = put_bit(pri_new, LEVEL1_POS, wbyte0_q[LEVEL1_POS]);
    // pin low: lock may only rise; pin high: free
    pri_new = put_bit(pri_new, LOCK_POS, wbyte0_q[LOCK_POS] |
      (!wp_pin_high & status_pri_o[LOCK_POS]));
  end

  // value stored by a status write: live busy, latch dropped
  reg [7:0] pri_wr;
  always @* begin
    pri_wr = put_bit(pri_new, BUSY_POS, busy_sync_q[1]);
    pri_wr = put_bit(pri_wr, WRITE_LATCH_POS, 1'b0);
  end

  // second byte only touches the two sector protect bits
  reg [7:0] sec_wr;
  always @* begin
    sec_wr = put_bit(status_sec_o, TOP_PROT_POS, wbyte1_q[TOP_PROT_POS]);
    sec_wr = put_bit(sec_wr, BOT_PROT_POS, wbyte1_q[BOT_PROT_POS]);
  end

  // serial engine and command execution
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      state_q <= ST_OPC;
      opc_q <= 8'h00;
      shin_q <= 8'h00;
      bitcnt_q <= 5'd0;
      wcnt_q <= 5'd0;
      idx_q <= 2'd0;
      shout_q <= 8'h00;
      wbyte0_q <= 8'h00;
      wbyte1_q <= 8'h00;
      armed_q <= 1'b0;
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
      status_pri_o <= `STATUS_PRI_RESET;
      status_sec_o <= `STATUS_SEC_RESET;
    end else begin
      // busy bit follows the internal cycle; write_disable_cmd never stops it
      status_pri_o[BUSY_POS] <= busy_sync_q[1];
      // a new frame always starts with an opcode
      if (sel_fall) begin
        state_q <= ST_OPC;
        bitcnt_q <= 5'd0;
        wcnt_q <= 5'd0;
        idx_q <= 2'd0;
      end
      if (sel_rise) begin
        sdo_oe_o <= 1'b0;
        // commands take effect only here, after a whole opcode
        if (state_q != ST_OPC && wcnt_q == 5'd0) begin
          if (opc_q == WRITE_ENABLE_OPC) begin
            status_pri_o[WRITE_LATCH_POS] <= 1'b1;
          end else if (opc_q == `OPC_WRITE_DISABLE) begin
            status_pri_o[WRITE_LATCH_POS] <= 1'b0;
            status_pri_o[AUTO_INC_POS] <= 1'b0;
          end
        end
        // arm lasts for the next instruction only
        armed_q <= (opc_q == STATUS_WRITE_ARM_OPC) &&
          (state_q == ST_SKIP) && (wcnt_q == 5'd0);
        if (wsr_go) begin
          status_pri_o <= pri_wr;
          if (wcnt_q == 5'd16) begin
            status_sec_o <= sec_wr;
          end
        end
      end
      // set wins over a write disable in the same cycle
      if (auto_inc_set_i) begin
        status_pri_o[AUTO_INC_POS] <= 1'b1;
      end
      // shift in on the serial clock rise
      if (sck_rise) begin
        shin_q <= opc_next;
        bitcnt_q <= byte_done ? 5'd0 : bitcnt_q + 5'd1;
        case (state_q)
          ST_OPC: begin
            // decode the opcode into the frame state
            if (byte_done) begin
              opc_q <= opc_next;
              idx_q <= 2'd0;
              wcnt_q <= 5'd0;
              if (opc_next == `OPC_STATUS_READ) begin
                state_q <= ST_STAT1;
              end else if (opc_next == STATUS_READ_SECOND_OPC) begin
                state_q <= ST_STAT2;
              end else if (opc_next == `OPC_STD_IDENT) begin
                state_q <= ST_STDID;
              end else if (opc_next == `OPC_LEGACY_IDENT_A ||
                  opc_next == `OPC_LEGACY_IDENT_B) begin
                state_q <= ST_LADDR;
              end else if (opc_next == STATUS_WRITE_OPC) begin
                state_q <= ST_WDATA;
              end else begin
                state_q <= ST_SKIP;
              end
            end
          end
          ST_LADDR: begin
            // count address bits; the last one picks the first code
            wcnt_q <= wcnt_q + 5'd1;
            if (wcnt_q == ADDR_LAST[4:0]) begin
              state_q <= ST_LID;
              idx_q <= {1'b0, opc_next[0]};
            end
          end
          ST_WDATA: begin
            // count stops past limit so extra bits spoil the length
            if (wcnt_q != 5'd31) begin
              wcnt_q <= wcnt_q + 5'd1;
            end
            // first data byte feeds the primary register
            if (byte_done && wcnt_q == 5'd7) begin
              wbyte0_q <= opc_next;
            end
            // second data byte feeds the secondary register
            if (byte_done && wcnt_q == 5'd15) begin
              wbyte1_q <= opc_next;
            end
          end
          ST_SKIP: begin
            // any clock after a no-data opcode voids it
            wcnt_q <= 5'd1;
          end
          default: begin
          end
        endcase
      end
      // shift out on the serial clock fall, msb first
      if (sck_fall) begin
        if (answer_state(state_q)) begin
          sdo_oe_o <= 1'b1;
          if (bitcnt_q == 5'd0) begin
            // byte boundary: load the next answer byte
            sdo_o <= ans_byte[7];
            shout_q <= {ans_byte[6:0], 1'b0};
            if (state_q == ST_STDID && idx_q != 2'd2) begin
              idx_q <= idx_q + 2'd1;
            end else if (state_q == ST_LID) begin
              idx_q <= {1'b0, ~idx_q[0]};
            end
          end else begin
            // inside a byte: next bit from the shift register
            sdo_o <= shout_q[7];
            shout_q <= {shout_q[6:0], 1'b0};
          end
        end
      end
    end
  end

endmodule // spi_flash_status_id_commands
`default_nettype wire

/* File: tb/spi_flash_status_id_checker.sv */
// checker for the status and ident command block, port view only
// assumes one clock domain and a synchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module spi_flash_status_id_checker (
  input wire logic clk_sys_i, // system clock
  input wire logic rst_n_i, // reset, active low
  input wire logic chip_sel_n_i, // host select pin
  input wire logic prog_busy_i, // internal cycle running
  input wire logic write_prot_n_i, // write-protect pin
  input wire logic sdo_oe_o, // serial out drive enable
  input wire logic [7:0] status_pri_o, // primary status
  input wire logic [7:0] status_sec_o // secondary status
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // busy bit follows the internal cycle flag
  a_busy_follows: assert property (!$stable(prog_busy_i) |-> ##[1:4]
    (status_pri_o[0] == prog_busy_i)) else $error("busy bit late");
  // output driver only inside a frame
  a_oe_idle: assert property (chip_sel_n_i [*5] |-> !sdo_oe_o)
    else $error("drive enable outside frame");
  a_oe_in_frame: assert property ($rose(sdo_oe_o) |-> !chip_sel_n_i)
    else $error("drive enable rose while deselected");
  // status updates only after select has risen
  a_latch_set: assert property ($rose(status_pri_o[1]) |-> chip_sel_n_i)
    else $error("latch set inside frame");
  a_latch_clear: assert property ($fell(status_pri_o[1]) |-> chip_sel_n_i)
    else $error("latch cleared inside frame");
  a_autoinc_clear: assert property ($fell(status_pri_o[6]) |-> chip_sel_n_i)
    else $error("auto increment cleared inside frame");
  a_protect_at_rise: assert property (!$stable({status_pri_o[7],
    status_pri_o[3:2]}) |-> chip_sel_n_i) else $error("protect bits moved");
  a_sec_at_rise: assert property (!$stable(status_sec_o) |-> chip_sel_n_i)
    else $error("secondary changed inside frame");
  // lock-down with the pin low
  a_lock_holds: assert property ((!write_prot_n_i [*4] ##0 status_pri_o[7])
    |=> status_pri_o[7]) else $error("lock released while pin low");
  a_locked_frozen: assert property ((!write_prot_n_i [*4] ##0 status_pri_o[7])
    |=> $stable({status_pri_o[3:2], status_sec_o[3:2]}))
    else $error("locked status altered");
endmodule // spi_flash_status_id_checker
bind spi_flash_status_id_commands spi_flash_status_id_checker
  spi_flash_status_id_checker_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
  .chip_sel_n_i(chip_sel_n_i), .prog_busy_i(prog_busy_i),
  .write_prot_n_i(write_prot_n_i), .sdo_oe_o(sdo_oe_o),
  .status_pri_o(status_pri_o), .status_sec_o(status_sec_o));
`default_nettype wire

/* File: tb/spi_host_model.sv */
// spi host model: mode 0 frames on select, serial clock and data
// assumes the flash block samples these pins with its own clock
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic chip_sel_n_o, // select, active low
  output logic sclk_o, // serial clock, still outside frames
  output logic sdi_o, // data to device
  input wire logic sdo_i // data from device
);
  // idle pins
  initial begin
    chip_sel_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // one frame: opcode, n more bits, last 32 samples returned in rx
  task automatic frame(input logic [7:0] op, input logic [31:0] dat,
      input int n, output logic [31:0] rx);
    logic [39:0] sr;
    sr = {op, dat};
    rx = 32'h0;
    chip_sel_n_o = 1'b0;
    for (int i = 0; i < 8 + n; i++) begin
      sdi_o = sr[39];
      sr = sr << 1;
      #400 sclk_o = 1'b1;
      #390;
      if (i >= 8) rx = {rx[30:0], sdo_i}; // answer bits only
      #10 sclk_o = 1'b0;
    end
    #400 chip_sel_n_o = 1'b1;
    sdi_o = ~sdi_o; // no stale bit after release
    #1200;
  endtask
endmodule // spi_host_model
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the status and ident command block
// assumes default opcodes, bit positions and ident codes of the design
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic busy = 1'b0;
  logic auto_inc = 1'b0;
  logic wp_n = 1'b1;
  logic [7:0] exp_pri = 8'h00;
  logic [7:0] exp_sec = 8'h00;
  logic [31:0] rx;
  int bad_count = 0;
  int total_checks = 0;
  wire cs_n, sclk, sdi, sdo, sdo_oe;
  // released line shows the inverse of the last driven bit
  wire sdo_line = sdo_oe ? sdo : ~sdo;
  wire [7:0] pri, sec;
  spi_flash_status_id_commands spi_flash_status_id_commands_i (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .chip_sel_n_i(cs_n),
    .sclk_i(sclk), .sdi_i(sdi), .prog_busy_i(busy),
    .auto_inc_set_i(auto_inc), .write_prot_n_i(wp_n), .sdo_o(sdo),
    .sdo_oe_o(sdo_oe), .status_pri_o(pri), .status_sec_o(sec));
  spi_host_model spi_host_model_i (.chip_sel_n_o(cs_n), .sclk_o(sclk),
    .sdi_o(sdi), .sdo_i(sdo_line));
  // clock
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic pins(logic b, logic w);
    @(posedge clk_sys_i);
    #1;
    busy = b;
    wp_n = w;
  endtask
  // armed or latch-enabled status write, expectation from the lock rules
  task automatic wr(logic [7:0] d, logic [7:0] d2, int nb, logic write_enable_cmd);
    logic ok;
    ok = wp_n | ~exp_pri[7];
    spi_host_model_i.frame(write_enable_cmd ? 8'h06 : 8'h50, 32'h0, 0, rx);
    spi_host_model_i.frame(8'h01, {d, d2, 16'h0}, nb, rx);
    if (ok && (nb == 8 || nb == 16)) exp_pri = (exp_pri & 8'h73) | (d & 8'h8C);
    if (ok && nb == 16) exp_sec = (exp_sec & 8'hF3) | (d2 & 8'h0C);
    exp_pri[1] = 1'b0;
    check("status_pri", {24'h0, exp_pri}, {24'h0, pri});
    check("status_sec", {24'h0, exp_sec}, {24'h0, sec & 8'h0C});
  endtask
  // watchdog
  initial begin
    #8000000;
    bad_count++;
    wrap_up();
  end
  // main sequence
  initial begin
    void'($urandom(32'heb49b6d9));
    repeat (3) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 check("reset_pri", 32'h0, {24'h0, pri});
    check("reset_sec", 32'h0, {24'h0, sec});
    pins(1'b1, 1'b1);
    spi_host_model_i.frame(8'h05, 32'h0, 16, rx);
    check("busy_read", {16'h0, {2{exp_pri | 8'h01}}}, rx);
    spi_host_model_i.frame(8'h06, 32'h0, 0, rx);
    exp_pri[1] = 1'b1;
    check("write_enable_cmd", {24'h0, exp_pri | 8'h01}, {24'h0, pri});
    @(posedge clk_sys_i);
    #1 auto_inc = 1'b1;
    @(posedge clk_sys_i);
    #1 auto_inc = 1'b0;
    check("autoinc", {24'h0, exp_pri | 8'h41}, {24'h0, pri});
    spi_host_model_i.frame(8'h04, 32'h0, 0, rx);
    exp_pri[1] = 1'b0;
    check("write_disable_cmd", {24'h0, exp_pri | 8'h01}, {24'h0, pri});
    pins(1'b0, 1'b1);
    spi_host_model_i.frame(8'h01, 32'h8C00_0000, 8, rx);
    check("no_arm", {24'h0, exp_pri}, {24'h0, pri});
    spi_host_model_i.frame(8'h50, 32'h0, 0, rx);
    spi_host_model_i.frame(8'h05, 32'h0, 8, rx);
    check("idle_read", {24'h0, exp_pri}, rx);
    spi_host_model_i.frame(8'h01, 32'h8C00_0000, 8, rx);
    check("arm_gap", {24'h0, exp_pri}, {24'h0, pri});
    wr(8'h8C, 8'h00, 12, 1'b0);
    wr(8'h04, 8'h00, 8, 1'b1);
    wr(8'h80, 8'h0C, 16, 1'b0);
    pins(1'b0, 1'b0);
    wr(8'h0C, 8'h08, 16, 1'b0);
    pins(1'b0, 1'b1);
    wr(8'h08, 8'h04, 16, 1'b0);
    pins(1'b0, 1'b0);
    wr(8'h84, 8'h00, 8, 1'b0);
    for (int i = 0; i < 12; i++) begin
      pins(1'b0, 1'($urandom));
      wr(8'($urandom), 8'($urandom), ($urandom % 2) ? 16 : 8, 1'b0);
    end
    spi_host_model_i.frame(8'h35, 32'h0, 16, rx);
    check("second_read", {16'h0, {2{exp_sec}}}, rx & 32'h0C0C);
    spi_host_model_i.frame(8'h9F, 32'h0, 32, rx);
    check("std_ident", 32'h5A3C_1212, rx);
    spi_host_model_i.frame(8'h9F, 32'h0, 12, rx);
    spi_host_model_i.frame(8'h05, 32'h0, 8, rx);
    check("after_cut", {24'h0, exp_pri}, rx);
    spi_host_model_i.frame(8'h90, 32'h0, 56, rx);
    check("legacy_a", 32'h5A12_5A12, rx);
    spi_host_model_i.frame(8'hAB, 32'h0000_0100, 56, rx);
    check("legacy_b", 32'h125A_125A, rx);
    // second reset between frames
    @(posedge clk_sys_i);
    #1 rst_n_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    exp_pri = 8'h00;
    exp_sec = 8'h00;
    repeat (2) @(posedge clk_sys_i);
    #1 check("reset2_pri", 32'h0, {24'h0, pri});
    check("reset2_sec", 32'h0, {24'h0, sec});
    repeat (2) @(posedge clk_sys_i);
    #1 spi_host_model_i.frame(8'h05, 32'h0, 8, rx);
    check("reset2_read", {24'h0, exp_pri}, rx);
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
